// ---- common/cid_regs.vh ----
// register map, field positions and codes of the card info tuple decoder
// included by the decoder; no logic here
`ifndef CID_REGS_VH
`define CID_REGS_VH
// register byte addresses
`define CID_CTRL 8'h00
`define CID_STAT 8'h04
`define CID_IRQ_STAT 8'h08
`define CID_IRQ_MASK 8'h0C
`define CID_DEV_INFO 8'h10
`define CID_VERS 8'h14
`define CID_TEXT 8'h18
`define CID_SIZE 8'h1C
// control bits
`define CID_CTRL_START 0
`define CID_CTRL_MODE 1
// irq bits
`define CID_IRQ_ENTRY 0
`define CID_IRQ_CHAR 1
`define CID_IRQ_DONE 2
`define CID_IRQ_ERR 3
`define CID_IRQ_W 4
// device type codes
`define CID_TYPE_HOLE 4'h0
`define CID_TYPE_DRAM 4'h7
`define CID_TYPE_IO 4'hD
`define CID_TYPE_EXT 4'hE
// tuple bytes
`define CID_VERS_CODE 8'h15
`define CID_MAJOR_EXP 8'h04
`define CID_MINOR_EXP 8'h00
`define CID_END_BYTE 8'hFF
`define CID_ZERO_BYTE 8'h00
`define CID_STR_COUNT 3'h4
// unit size 512 bytes as a shift
`define CID_UNIT_SHIFT 5'h09
`endif

// ---- rtl/cid_decoder.v ----
// card info tuple decoder: takes attribute bytes one at a time, decodes
// device info entries or the version/product tuple, axi4-lite registers
// takes at most one byte per cycle, paced by byte_valid/byte_ready, synchronous to core_clk
//
// How it works
// - device type from upper nibble
// - type codes decoded, 8-Ch and Fh reserved
// - extension bytes consumed while bit7 set
// - byte after type bytes is size
// - zero size byte discards entry
// - size bits 0-2 pick unit size
// - bits 3-7 hold unit count minus one
// - size FFh ends tuple, entry ignored
// - version tuple code 15h, then link
// - third byte is major version
// - fourth byte is minor version
// - manufacturer name until zero byte
// - product name follows, zero terminated
// - two more free text strings accepted
// - low nibble speed, bit3 protect switch flag; here bit3 stays in dev_speed, no separate flag
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "cid_regs.vh"

module cid_decoder
(
	input wire core_clk,
	input wire nrst,
	input wire byte_valid,
	input wire [7:0] byte_data,
	output reg byte_ready,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg irq
);

// ************************************
// states
// ************************************
localparam ST_IDLE = 4'h0;
localparam ST_D_CODE = 4'h1;
localparam ST_D_LINK = 4'h2;
localparam ST_D_TYPE = 4'h3;
localparam ST_D_EXT = 4'h4;
localparam ST_D_SIZE = 4'h5;
localparam ST_V_CODE = 4'h6;
localparam ST_V_LINK = 4'h7;
localparam ST_V_MAJ = 4'h8;
localparam ST_V_MIN = 4'h9;
localparam ST_V_STR = 4'hA;
localparam ST_V_CHR = 4'hB;
localparam ST_DONE = 4'hC;

reg [3:0] state;
reg mode;
reg busy;
reg err;
reg ended;
reg [3:0] dev_type;
reg [3:0] dev_speed;
reg ext_seen;
reg [7:0] pend_id;
reg pend_ext;
reg [7:0] size_byte;
reg [4:0] size_count;
reg [2:0] size_unit;
reg [31:0] region_bytes;
reg [7:0] link;
reg [7:0] major;
reg [7:0] minor;
reg [2:0] str_idx;
reg [7:0] last_char;
reg [7:0] entry_count;
reg [`CID_IRQ_W-1:0] irq_stat;
reg [`CID_IRQ_W-1:0] irq_mask;
reg [`CID_IRQ_W-1:0] ev;
reg have_aw;
reg have_w;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

wire take = byte_valid & byte_ready;
wire wr_fire = have_aw & have_w & ~s_axi_bvalid;
wire start_wr = wr_fire & (aw_addr == `CID_CTRL) & w_strb[0] &
	w_data[`CID_CTRL_START];
wire clr_wr = wr_fire & (aw_addr == `CID_IRQ_STAT) & w_strb[0];

// ************************************
// region size
// ************************************
// unit size
// count plus one
// 512 << (2*code) times (count+1); 8M*32 fits in 32 bits
function [31:0] region_of;
	input [7:0] sb;
	begin
		region_of = ({27'h0000000, sb[7:3]} + 32'h00000001) <<
			(`CID_UNIT_SHIFT + {1'b0, sb[2:0], 1'b0});
	end
endfunction

function is_reserved;
	input [3:0] t;
	begin
		is_reserved = (t > `CID_TYPE_DRAM) && (t < `CID_TYPE_IO) ||
			(t == 4'hF);
	end
endfunction

// ************************************
// byte parser
// ************************************
always @(posedge core_clk or negedge nrst)
begin
	if (!nrst)
	begin
		state <= ST_IDLE;
		busy <= 1'b0;
		err <= 1'b0;
		ended <= 1'b0;
		byte_ready <= 1'b0;
		dev_type <= 4'h0;
		dev_speed <= 4'h0;
		ext_seen <= 1'b0;
		pend_id <= 8'h00;
		pend_ext <= 1'b0;
		size_byte <= 8'h00;
		size_count <= 5'h00;
		size_unit <= 3'h0;
		region_bytes <= 32'h00000000;
		link <= 8'h00;
		major <= 8'h00;
		minor <= 8'h00;
		str_idx <= 3'h0;
		last_char <= 8'h00;
		entry_count <= 8'h00;
		ev <= {`CID_IRQ_W{1'b0}};
	end
	else
	begin
		ev <= {`CID_IRQ_W{1'b0}};
		if (start_wr)
		begin
			busy <= 1'b1;
			err <= 1'b0;
			ended <= 1'b0;
			byte_ready <= 1'b1;
			str_idx <= 3'h0;
			entry_count <= 8'h00;
			// mode of this same write, not the stored one
			state <= w_data[`CID_CTRL_MODE] ? ST_V_CODE : ST_D_CODE;
		end
		else if (take)
		begin
			case (state)
			ST_D_CODE:
				state <= ST_D_LINK;
			ST_D_LINK:
			begin
				link <= byte_data;
				state <= ST_D_TYPE;
			end
			ST_D_TYPE:
			begin
				// kept aside until size is valid
				pend_id <= byte_data;
				pend_ext <= 1'b0;
				if (is_reserved(byte_data[7:4]))
				begin
					err <= 1'b1;
					ev[`CID_IRQ_ERR] <= 1'b1;
				end
				state <= (byte_data[7:4] == `CID_TYPE_EXT) ?
					ST_D_EXT : ST_D_SIZE;
			end
			ST_D_EXT:
			begin
				pend_ext <= 1'b1;
				if (!byte_data[7])
					state <= ST_D_SIZE;
			end
			ST_D_SIZE:
			begin
				if (byte_data == `CID_END_BYTE)
				begin
					state <= ST_DONE;
					byte_ready <= 1'b0;
					ended <= 1'b1;
					ev[`CID_IRQ_DONE] <= 1'b1;
				end
				else if (byte_data == `CID_ZERO_BYTE)
					state <= ST_D_TYPE;
				else
				begin
					dev_type <= pend_id[7:4];
					dev_speed <= pend_id[3:0];
					ext_seen <= pend_ext;
					size_byte <= byte_data;
					size_count <= byte_data[7:3];
					size_unit <= byte_data[2:0];
					region_bytes <= region_of(byte_data);
					entry_count <= entry_count + 8'h01;
					ev[`CID_IRQ_ENTRY] <= 1'b1;
					state <= ST_D_TYPE;
				end
			end
			ST_V_CODE:
			begin
				if (byte_data != `CID_VERS_CODE)
				begin
					err <= 1'b1;
					ev[`CID_IRQ_ERR] <= 1'b1;
				end
				state <= ST_V_LINK;
			end
			ST_V_LINK:
			begin
				link <= byte_data;
				state <= ST_V_MAJ;
			end
			ST_V_MAJ:
			begin
				major <= byte_data;
				if (byte_data != `CID_MAJOR_EXP)
				begin
					err <= 1'b1;
					ev[`CID_IRQ_ERR] <= 1'b1;
				end
				state <= ST_V_MIN;
			end
			ST_V_MIN:
			begin
				minor <= byte_data;
				if (byte_data != `CID_MINOR_EXP)
				begin
					err <= 1'b1;
					ev[`CID_IRQ_ERR] <= 1'b1;
				end
				state <= ST_V_STR;
			end
			ST_V_STR:
			begin
				if (byte_data == `CID_END_BYTE)
				begin
					state <= ST_DONE;
					byte_ready <= 1'b0;
					ended <= 1'b1;
					ev[`CID_IRQ_DONE] <= 1'b1;
				end
				else if (byte_data == `CID_ZERO_BYTE)
					str_idx <= str_idx + 3'h1;
				else
				begin
					last_char <= byte_data;
					ev[`CID_IRQ_CHAR] <= 1'b1;
					state <= ST_V_CHR;
				end
			end
			ST_V_CHR:
			begin
				if (byte_data == `CID_ZERO_BYTE)
				begin
					str_idx <= str_idx + 3'h1;
					state <= ST_V_STR;
				end
				else
				begin
					last_char <= byte_data;
					ev[`CID_IRQ_CHAR] <= 1'b1;
				end
			end
			default:
				state <= state;
			endcase
		end
		// intake already stopped; a start in this cycle keeps its state
		if (state == ST_DONE && !start_wr)
		begin
			busy <= 1'b0;
			state <= ST_IDLE;
		end
	end
end

// ************************************
// axi4-lite slave
// ************************************
// a write accepts address and data in either order, answers after both
always @(posedge core_clk or negedge nrst)
begin
	if (!nrst)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		have_aw <= 1'b0;
		have_w <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		mode <= 1'b0;
		irq_mask <= {`CID_IRQ_W{1'b0}};
		irq_stat <= {`CID_IRQ_W{1'b0}};
		irq <= 1'b0;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_addr <= s_axi_awaddr;
			have_aw <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			have_w <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (wr_fire)
		begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= 2'h0;
			case (aw_addr)
			`CID_CTRL:
				if (w_strb[0])
					mode <= w_data[`CID_CTRL_MODE];
			`CID_IRQ_MASK:
				if (w_strb[0])
					irq_mask <= w_data[`CID_IRQ_W-1:0];
			`CID_IRQ_STAT, `CID_STAT, `CID_DEV_INFO, `CID_VERS,
			`CID_TEXT, `CID_SIZE:
				s_axi_bresp <= 2'h0;
			default:
				s_axi_bresp <= 2'h2;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		// set wins over write-one-to-clear
		irq_stat <= (irq_stat & ~(clr_wr ? w_data[`CID_IRQ_W-1:0] :
			{`CID_IRQ_W{1'b0}})) | ev;
		irq <= |((irq_stat & ~(clr_wr ? w_data[`CID_IRQ_W-1:0] :
			{`CID_IRQ_W{1'b0}}) | ev) & irq_mask);
	end
end

always @(posedge core_clk or negedge nrst)
begin
	if (!nrst)
	begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end
	else
	begin
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`CID_CTRL:
				s_axi_rdata <= {30'h0, mode, 1'b0};
			`CID_STAT:
				s_axi_rdata <= {16'h0, entry_count, 1'b0, str_idx,
					1'b0, ended, err, busy};
			`CID_IRQ_STAT:
				s_axi_rdata <= {28'h0, irq_stat};
			`CID_IRQ_MASK:
				s_axi_rdata <= {28'h0, irq_mask};
			`CID_DEV_INFO:
				s_axi_rdata <= {size_byte, dev_speed, dev_type,
					ext_seen, 2'h0, size_count, 5'h00, size_unit};
			`CID_VERS:
				s_axi_rdata <= {8'h0, link, major, minor};
			`CID_TEXT:
				s_axi_rdata <= {21'h0, str_idx, last_char};
			`CID_SIZE:
				s_axi_rdata <= region_bytes;
			default:
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule // cid_decoder

// ---- tb/cid_asserts.sv ----
// port checker of the tuple decoder
// bound to each cid_decoder; one clock
`timescale 1ns/1ns
module cid_asserts
(
	input wire core_clk,
	input wire nrst,
	input wire byte_valid,
	input wire [7:0] byte_data,
	input wire byte_ready,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	// ****
	// properties
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	end_stop_a:
	assert property ($fell(byte_ready) |->
		$past(byte_valid && byte_data == 8'hFF)) else $error("early stop");
	start_rise_a:
	assert property ($rose(byte_ready) |-> s_axi_bvalid)
		else $error("no start");
	rd_answer_a:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no rdata");
	rd_cause_a:
	assert property ($rose(s_axi_rvalid) |->
		$past(s_axi_arvalid && s_axi_arready)) else $error("stray rvalid");
	rd_once_a:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stuck");
	wr_answer_a:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("no bvalid");
	wr_once_a:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	one_write_a:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write overlap");
	one_read_a:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("overlap");
	bresp_code_a:
	assert property (s_axi_bvalid |-> !s_axi_bresp[0]) else $error("bresp");
endmodule // cid_asserts

bind cid_decoder cid_asserts i_chk (.core_clk, .nrst, .byte_valid,
	.byte_data, .byte_ready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// ---- tb/cid_card_mem.sv ----
// card attribute memory model offering tuple bytes
// bench loads mem, len and ptr while byte_valid is low
`timescale 1ns/1ns
module cid_card_mem
(
	input wire core_clk,
	input wire nrst,
	input wire slow,
	input wire byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	logic [7:0] mem [0:15];
	int len;
	int ptr;
	// ****
	// byte source
	// ****
	// idle bus toggles so no stale byte can pass for data
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
		end
		else if (byte_valid && byte_ready)
		begin
			byte_valid <= !slow && ptr + 1 < len;
			byte_data <= (slow || ptr + 1 >= len) ? ~byte_data : mem[ptr + 1];
			ptr <= ptr + 1;
		end
		else if (!byte_valid && ptr < len)
		begin
			byte_valid <= 1'b1;
			byte_data <= mem[ptr];
		end
		else if (!byte_valid)
			byte_data <= ~byte_data;
	end
endmodule // cid_card_mem

// ---- tb/test_card_info_tuple_decoder.sv ----
// bench of the tuple decoder: axi master, card model, checks
// assumes cid_regs.vh is on the include path
`timescale 1ns/1ns
`include "cid_regs.vh"
module test_card_info_tuple_decoder;
	logic core_clk, nrst, slow, byte_valid, byte_ready, irq;
	logic [7:0] byte_data, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int fails, cmp_count, cyc;
	cid_decoder i_dut (.core_clk, .nrst, .byte_valid, .byte_data,
		.byte_ready, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq);
	cid_card_mem i_mem (.core_clk, .nrst, .slow, .byte_ready,
		.byte_valid, .byte_data);
	// ****
	// tasks
	// ****
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid));
		resp = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!(s_axi_rvalid && !s_axi_arvalid));
		rv = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task ld(input logic [127:0] v, input int n);
		for (int k = 0; k < n; k++)
			i_mem.mem[k] = v[8 * (n - 1 - k) +: 8];
		i_mem.len = n;
		i_mem.ptr = 0;
	endtask
	// start a parse and wait until the end byte stops intake
	task run(input logic [31:0] mode);
		int n;
		n = 0;
		wr(`CID_CTRL, mode);
		while (!byte_ready && n < 9)
		begin
			@(posedge core_clk);
			n++;
		end
		while (byte_ready && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		chk(byte_ready, 0);
	endtask
	task t_map;
		rd(8'h20);
		chk(resp, 2'h2);
		chk(rv, 32'h0);
		wr(8'h24, 32'hFFFFFFFF);
		chk(resp, 2'h2);
		$display("t_map done");
	endtask
	task t_types;
		logic [3:0] sp;
		logic [4:0] c;
		logic [2:0] u;
		for (int t = 0; t < 16; t++)
		begin
			sp = 4'(15 - t);
			c = 5'(2 * t + 1);
			u = 3'(t + 1);
			ld({8'h01, 8'h04, 4'(t), sp, c, u, 8'h6F, 8'hFF}, 6);
			if (t != 14)
			begin
				run(32'h1);
				rd(`CID_DEV_INFO);
				chk(rv[23:16], {sp, 4'(t)});
				chk(rv[12:0], {c, 5'h0, u});
				rd(`CID_SIZE);
				chk(rv, (c + 32'h1) << (9 + 2 * u));
				rd(`CID_STAT);
				chk(rv[15:8], 1);
				chk(rv[1], (t > 7 && t < 13) || t == 15);
			end
		end
		$display("t_types done");
	endtask
	task t_ext;
		ld({8'h01, 8'h09, 8'hE3, 8'h85, 8'h02, 8'h11, 8'h63, 8'h00,
			8'h41, 8'h08, 8'h7A, 8'hFF}, 12);
		run(32'h1);
		rd(`CID_STAT);
		chk(rv[15:8], 2);
		chk(rv[1], 0);
		rd(`CID_DEV_INFO);
		chk(rv[19:16], 4);
		chk(rv[15], 0);
		rd(`CID_SIZE);
		chk(rv, 1024);
		$display("t_ext done");
	endtask
	task t_vers;
		slow <= 1'b1;
		ld({8'h15, 8'h0E, 8'h04, 8'h00, 8'h41, 8'h42, 8'h00, 8'h43, 8'h00,
			8'h4C, 8'h00, 8'h50, 8'h00, 8'hFF}, 14);
		run(32'h3);
		rd(`CID_VERS);
		chk(rv[23:0], 24'h0E0400);
		rd(`CID_STAT);
		chk(rv[6:4], 4);
		chk(rv[2:1], 2'h2);
		ld({8'h15, 8'h06, 8'h05, 8'h01, 8'h5A, 8'h00, 8'hFF}, 7);
		run(32'h3);
		rd(`CID_STAT);
		chk(rv[6:4], 1);
		chk(rv[2:1], 2'h3);
		slow <= 1'b0;
		$display("t_vers done");
	endtask
	task t_irq;
		// earlier runs left status bits set; start from clean status
		wr(`CID_IRQ_STAT, 32'hF);
		wr(`CID_IRQ_MASK, 32'h4);
		repeat (2) @(posedge core_clk);
		chk(irq, 0);
		ld({8'h01, 8'h02, 8'h6F, 8'hFF}, 4);
		run(32'h1);
		rd(`CID_IRQ_STAT);
		chk({rv[2], irq}, 2'h3);
		wr(`CID_IRQ_MASK, 32'h0);
		repeat (2) @(posedge core_clk);
		chk(irq, 0);
		wr(`CID_IRQ_MASK, 32'h4);
		repeat (2) @(posedge core_clk);
		chk(irq, 1);
		// write one clears the done bit
		wr(`CID_IRQ_STAT, 32'h4);
		repeat (2) @(posedge core_clk);
		rd(`CID_IRQ_STAT);
		chk({rv[2], irq}, 2'h0);
		$display("t_irq done");
	endtask
	// ****
	// clock, timeout, sequence
	// ****
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// a hang counts as a mismatch
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	initial
	begin
		// bready and rready stay high: every answer is taken at once
		{nrst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h1;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h10000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{fails, cmp_count, cyc} = 0;
		i_mem.len = 0;
		i_mem.ptr = 0;
		repeat (8) @(posedge core_clk);
		chk({byte_ready, irq}, 0);
		nrst <= 1'b1;
		@(posedge core_clk);
		t_map;
		t_types;
		t_ext;
		t_vers;
		t_irq;
		tally_and_finish;
	end
endmodule // test_card_info_tuple_decoder
